// ==== include/floppy_regs_pkg.sv ====
package floppy_regs_pkg;

    // Register indices; the byte address on APB is four times the index
    localparam logic [9:0] IDX_DIGITAL_OUTPUT = 10'h3f2;
    localparam logic [9:0] IDX_TAPE_DRIVE_TYPE = 10'h3f3;
    localparam logic [9:0] IDX_RATE_STATUS = 10'h3f4;
    localparam logic [9:0] IDX_COMMAND_DATA = 10'h3f5;
    localparam logic [9:0] IDX_DISK_INPUT = 10'h3f7;
    localparam logic [9:0] IDX_CONFIG_SIX = 10'h3f8;
    localparam logic [9:0] IDX_CONFIG_SEVEN = 10'h3f9;
    localparam logic [9:0] IDX_ENGINE_CFG = 10'h3fa;
    localparam logic [9:0] IDX_FIELD_A_TRACK = 10'h3fb;
    localparam int ADDR_W = 12;

    // Rate select register fields
    localparam int RSC_SOFT_RESET_BIT = 7;
    localparam int RSC_LOW_POWER_BIT = 6;
    localparam int RSC_FIELD_A_LSB = 2;
    localparam logic [7:0] RSC_RESET = 8'h02;
    localparam logic [2:0] FIELD_A_OFF = 3'h7;
    localparam logic [2:0] FIELD_A_DEFAULT = 3'h0;

    // Digital output register: bit 2 low holds the controller in reset
    localparam int DOR_RESET_N_BIT = 2;
    localparam logic [7:0] DOR_RESET = 8'h00;

    // Engine configuration fields
    localparam int CFG_DRIVE_OPT_LSB = 0;
    localparam int CFG_IDENT_BIT = 2;
    localparam int CFG_FIFO_EN_BIT = 3;
    localparam int CFG_THRESH_LSB = 4;
    localparam logic [7:0] CFG_RESET = 8'h04;
    localparam logic [7:0] FIELD_A_TRACK_RESET = 8'h00;

    // Rate codes
    localparam logic [1:0] RATE_1M = 2'h3;
    localparam logic [1:0] RATE_500K = 2'h0;
    localparam logic [1:0] RATE_ALT = 2'h1;
    localparam logic [1:0] RATE_250K = 2'h2;
    localparam logic [1:0] DRIVE_OPT_NORMAL = 2'h0;
    localparam logic [1:0] DRIVE_OPT_THREE_MODE = 2'h1;

    // Resolved MFM data rate
    typedef enum logic [2:0] {
        KBPS_250 = 3'h0,
        KBPS_300 = 3'h1,
        KBPS_500 = 3'h2,
        KBPS_1000 = 3'h3,
        KBPS_2000 = 3'h4
    } data_rate_e;

    // Precompensation delay in half steps of 20.83 ns
    localparam logic [3:0] FIELD_A_DEF_2M = 4'h1;
    localparam logic [3:0] FIELD_A_DEF_1M = 4'h2;
    localparam logic [3:0] FIELD_A_DEF_LOW = 4'h6;

    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_AW = 4;

endpackage

// ==== verilog/floppy_host_status_rate_regs.sv ====
`timescale 1ns/1ps
module floppy_host_status_rate_regs
    import floppy_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command sequencer status, same clock
    input wire logic [3:0] driveSeekFlag,
    input wire logic commandBusy,
    input wire logic nonDmaExec,
    input wire logic transferDirection,
    input wire logic requestForMaster,
    input wire logic execPhase,
    // Sequencer read data toward the host
    input wire logic engRdValid,
    input wire logic [7:0] engRdData,
    // Disk cable pin
    input wire logic diskChange,
    // Toward the sequencer
    output logic [7:0] cmdWrData,
    output logic cmdWrStrobe,
    output logic hostRdStrobe,
    output logic fifoOverrun,
    output logic fifoThresholdHit,
    output logic softReset,
    output logic lowPower,
    // Data rate and precompensation
    output logic [2:0] dataRate,
    output logic [3:0] precompHalfSteps,
    output logic [7:0] precompStartTrack,
    // Drive pins
    output logic densityOutput,
    output logic [1:0] rateOutputPin
);

    logic [7:0] rsc_r, rsc_nxt;
    logic [1:0] rateCode_r, rateCode_nxt;
    logic [1:0] tapeSel_r, tapeSel_nxt;
    logic [7:0] dor_r, dor_nxt;
    logic [7:0] cr6_r, cr6_nxt;
    logic [7:0] cr7_r, cr7_nxt;
    logic [7:0] cfg_r, cfg_nxt;
    logic [7:0] track_r, track_nxt;
    logic lowPower_r, lowPower_nxt;
    logic swPulse_r, swPulse_nxt;
    logic softReset_r, softReset_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic [7:0] cmdWrData_r, cmdWrData_nxt;
    logic cmdWrStrobe_r, cmdWrStrobe_nxt;
    logic hostRdStrobe_r, hostRdStrobe_nxt;
    logic overrun_r, overrun_nxt;
    logic thresh_r, thresh_nxt;
    logic [2:0] dataRate_r, dataRate_nxt;
    logic [3:0] field_a_r, field_a_nxt;
    logic density_r, density_nxt;
    logic [1:0] ratePin_r, ratePin_nxt;
    logic [2:0] dskSync_r;
    logic dskLevel_r, dskLevel_nxt;
    logic execPrev_r;

    logic [7:0] fifoMem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wrPtr_r, wrPtr_nxt;
    logic [FIFO_AW-1:0] rdPtr_r, rdPtr_nxt;
    logic [FIFO_AW:0] count_r, count_nxt;

    logic access, doWrite, doRead;
    logic [9:0] index;
    logic fifoFull, fifoEmpty, push, pop, flush;
    logic request_for_master;
    logic [7:0] statusByte, tapeByte, readByte;
    logic [1:0] cr6Pair;
    logic mapped;

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cmdWrData = cmdWrData_r;
    assign cmdWrStrobe = cmdWrStrobe_r;
    assign hostRdStrobe = hostRdStrobe_r;
    assign fifoOverrun = overrun_r;
    assign fifoThresholdHit = thresh_r;
    assign softReset = softReset_r;
    assign lowPower = lowPower_r;
    assign dataRate = dataRate_r;
    assign precompHalfSteps = field_a_r;
    assign precompStartTrack = track_r;
    assign densityOutput = density_r;
    assign rateOutputPin = ratePin_r;

    // One wait state: the answer is registered so every output is a flop
    assign access = psel && penable && pready_r;
    assign doWrite = access && pwrite;
    assign doRead = access && !pwrite;
    assign index = paddr[ADDR_W-1:2];

    // With the FIFO off the buffer behaves as a single holding byte
    assign fifoFull = cfg_r[CFG_FIFO_EN_BIT] ?
        (count_r == (FIFO_AW+1)'(FIFO_DEPTH)) : (count_r != '0);
    assign fifoEmpty = (count_r == '0);
    assign flush = execPhase && !execPrev_r;
    assign push = engRdValid && !fifoFull && !flush;
    assign pop = doRead && (index == IDX_COMMAND_DATA) && !fifoEmpty;

    // Reading data is gated by buffered bytes during a read transfer
    always_comb
    begin
        request_for_master = requestForMaster;
        if (execPhase && transferDirection)
        begin
            request_for_master = !fifoEmpty;
        end
    end

    assign statusByte = {request_for_master, transferDirection, nonDmaExec, commandBusy,
        driveSeekFlag};
    assign cr6Pair = cr6_r[{dor_r[1:0], 1'b0} +: 2];
    assign tapeByte = {2'b00, cr6Pair, cr7_r[1], cr7_r[0], tapeSel_r};

    always_comb
    begin
        mapped = 1'b1;
        readByte = 8'h00;
        case (index)
            IDX_DIGITAL_OUTPUT: readByte = dor_r;
            IDX_TAPE_DRIVE_TYPE: readByte = tapeByte;
            IDX_RATE_STATUS: readByte = statusByte;
            IDX_COMMAND_DATA: readByte = fifoMem[rdPtr_r];
            IDX_DISK_INPUT: readByte = {!dskLevel_r, 7'h00};
            IDX_CONFIG_SIX: readByte = cr6_r;
            IDX_CONFIG_SEVEN: readByte = cr7_r;
            IDX_ENGINE_CFG: readByte = cfg_r;
            IDX_FIELD_A_TRACK: readByte = track_r;
            default: mapped = 1'b0;
        endcase
    end

    // Register file, control and bus answer
    always_comb
    begin
        rsc_nxt = rsc_r;
        rateCode_nxt = rateCode_r;
        tapeSel_nxt = tapeSel_r;
        dor_nxt = dor_r;
        cr6_nxt = cr6_r;
        cr7_nxt = cr7_r;
        cfg_nxt = cfg_r;
        track_nxt = track_r;
        lowPower_nxt = lowPower_r;
        swPulse_nxt = 1'b0;
        pready_nxt = psel && penable && !pready_r;
        pslverr_nxt = 1'b0;
        prdata_nxt = prdata_r;
        cmdWrData_nxt = cmdWrData_r;
        cmdWrStrobe_nxt = 1'b0;
        hostRdStrobe_nxt = 1'b0;
        if (psel && penable && !pready_r)
        begin
            pslverr_nxt = !mapped;
            prdata_nxt = pwrite ? 32'h0000_0000 : {24'h000000, readByte};
        end
        // Soft reset clears first, so a write in the same cycle still lands
        if (softReset_r)
        begin
            lowPower_nxt = 1'b0;
            cfg_nxt[CFG_FIFO_EN_BIT] = 1'b0;
        end
        if (doWrite)
        begin
            case (index)
                IDX_DIGITAL_OUTPUT: dor_nxt = pwdata[7:0];
                IDX_TAPE_DRIVE_TYPE: tapeSel_nxt = pwdata[1:0];
                IDX_RATE_STATUS:
                begin
                    rsc_nxt = {2'b00, pwdata[5:0]};
                    rateCode_nxt = pwdata[1:0];
                    if (pwdata[RSC_LOW_POWER_BIT])
                    begin
                        lowPower_nxt = 1'b1;
                    end
                    swPulse_nxt = pwdata[RSC_SOFT_RESET_BIT];
                end
                IDX_COMMAND_DATA:
                begin
                    cmdWrData_nxt = pwdata[7:0];
                    cmdWrStrobe_nxt = 1'b1;
                end
                IDX_DISK_INPUT: rateCode_nxt = pwdata[1:0];
                IDX_CONFIG_SIX: cr6_nxt = pwdata[7:0];
                IDX_CONFIG_SEVEN: cr7_nxt = pwdata[7:0];
                IDX_ENGINE_CFG: cfg_nxt = pwdata[7:0];
                IDX_FIELD_A_TRACK: track_nxt = pwdata[7:0];
                default: ;
            endcase
        end
        // Any data access or status read wakes the controller
        if (access && ((index == IDX_COMMAND_DATA) ||
            (!pwrite && index == IDX_RATE_STATUS)))
        begin
            lowPower_nxt = 1'b0;
        end
        if (doRead && index == IDX_COMMAND_DATA)
        begin
            hostRdStrobe_nxt = 1'b1;
        end
    end

    // Soft reset: held while DIGITAL_OUTPUT_REG bit 2 is low, pulsed by the self-clearing bit
    assign softReset_nxt = !dor_r[DOR_RESET_N_BIT] || swPulse_r;

    // FIFO and overrun
    always_comb
    begin
        wrPtr_nxt = wrPtr_r;
        rdPtr_nxt = rdPtr_r;
        count_nxt = count_r;
        if (flush || softReset_r)
        begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
            count_nxt = '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_nxt = wrPtr_r + 1'b1;
            end
            if (pop)
            begin
                rdPtr_nxt = rdPtr_r + 1'b1;
            end
            count_nxt = count_r + (FIFO_AW+1)'(push) - (FIFO_AW+1)'(pop);
        end
        // The sequencer ends the command and pads a write sector on this
        overrun_nxt = engRdValid && fifoFull && !flush;
        thresh_nxt = cfg_r[CFG_FIFO_EN_BIT] &&
            (count_r[FIFO_AW-1:0] >= cfg_r[CFG_THRESH_LSB +: 4] ||
             count_r[FIFO_AW]);
    end

    // Rate, density, rate pins and precompensation
    always_comb
    begin
        logic [1:0] opt;
        logic hiDens;
        logic [2:0] fa;
        opt = cfg_r[CFG_DRIVE_OPT_LSB +: 2];
        fa = rsc_r[RSC_FIELD_A_LSB +: 3];
        hiDens = (rateCode_r == RATE_1M) || (rateCode_r == RATE_500K);
        case (rateCode_r)
            RATE_1M: dataRate_nxt = KBPS_1000;
            RATE_500K: dataRate_nxt = KBPS_500;
            RATE_250K: dataRate_nxt = KBPS_250;
            RATE_ALT:
            begin
                if (opt == DRIVE_OPT_NORMAL)
                begin
                    dataRate_nxt = KBPS_300;
                end
                else if (opt == DRIVE_OPT_THREE_MODE)
                begin
                    dataRate_nxt = KBPS_500;
                end
                else
                begin
                    dataRate_nxt = KBPS_2000;
                end
            end
            default: dataRate_nxt = KBPS_250;
        endcase
        density_nxt = cfg_r[CFG_IDENT_BIT] ? hiDens : !hiDens;
        ratePin_nxt = (opt == DRIVE_OPT_NORMAL) ?
            {rateCode_r[1], rateCode_r[0]} : 2'b00;
        if (fa == FIELD_A_OFF)
        begin
            field_a_nxt = 4'h0;
        end
        else if (fa == FIELD_A_DEFAULT)
        begin
            if (dataRate_nxt == KBPS_2000)
            begin
                field_a_nxt = FIELD_A_DEF_2M;
            end
            else if (dataRate_nxt == KBPS_1000)
            begin
                field_a_nxt = FIELD_A_DEF_1M;
            end
            else
            begin
                field_a_nxt = FIELD_A_DEF_LOW;
            end
        end
        else if (dataRate_nxt == KBPS_2000)
        begin
            field_a_nxt = {1'b0, fa};
        end
        else
        begin
            field_a_nxt = {fa, 1'b0};
        end
    end

    // Disk change: a change counts once the second and third stages agree
    assign dskLevel_nxt = (dskSync_r[1] == dskSync_r[2]) ?
        dskSync_r[2] : dskLevel_r;

    always_ff @(posedge clk)
    begin
        if (push)
        begin
            fifoMem[wrPtr_r] <= engRdData;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rsc_r <= RSC_RESET;
            rateCode_r <= RSC_RESET[1:0];
            tapeSel_r <= 2'b00;
            dor_r <= DOR_RESET;
            cr6_r <= 8'h00;
            cr7_r <= 8'h00;
            cfg_r <= CFG_RESET;
            track_r <= FIELD_A_TRACK_RESET;
            lowPower_r <= 1'b0;
            swPulse_r <= 1'b0;
            softReset_r <= 1'b0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            cmdWrData_r <= 8'h00;
            cmdWrStrobe_r <= 1'b0;
            hostRdStrobe_r <= 1'b0;
            overrun_r <= 1'b0;
            thresh_r <= 1'b0;
            dataRate_r <= KBPS_250;
            field_a_r <= FIELD_A_DEF_LOW;
            density_r <= 1'b0;
            ratePin_r <= 2'b10;
            dskSync_r <= 3'b000;
            dskLevel_r <= 1'b0;
            execPrev_r <= 1'b0;
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            rsc_r <= rsc_nxt;
            rateCode_r <= rateCode_nxt;
            tapeSel_r <= tapeSel_nxt;
            dor_r <= dor_nxt;
            cr6_r <= cr6_nxt;
            cr7_r <= cr7_nxt;
            cfg_r <= cfg_nxt;
            track_r <= track_nxt;
            lowPower_r <= lowPower_nxt;
            swPulse_r <= swPulse_nxt;
            softReset_r <= softReset_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            prdata_r <= prdata_nxt;
            cmdWrData_r <= cmdWrData_nxt;
            cmdWrStrobe_r <= cmdWrStrobe_nxt;
            hostRdStrobe_r <= hostRdStrobe_nxt;
            overrun_r <= overrun_nxt;
            thresh_r <= thresh_nxt;
            dataRate_r <= dataRate_nxt;
            field_a_r <= field_a_nxt;
            density_r <= density_nxt;
            ratePin_r <= ratePin_nxt;
            dskSync_r <= {dskSync_r[1:0], diskChange};
            dskLevel_r <= dskLevel_nxt;
            execPrev_r <= execPhase;
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

endmodule

// ==== test/floppy_regs_props.sv ====
`timescale 1ns/1ps
module floppy_regs_props
    import floppy_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sequencer and rate side
    input wire logic [3:0] driveSeekFlag,
    input wire logic commandBusy,
    input wire logic [7:0] cmdWrData,
    input wire logic cmdWrStrobe,
    input wire logic softReset,
    input wire logic lowPower,
    input wire logic [2:0] dataRate
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic done, known, rateWr, statRd;
    logic [9:0] idx;
    logic [7:0] wByte;
    assign idx = paddr[11:2];
    assign wByte = pwdata[7:0];
    assign done = psel && penable && pready;
    assign rateWr = done && pwrite && idx == IDX_RATE_STATUS;
    assign statRd = done && !pwrite && idx == IDX_RATE_STATUS;
    // Index 0x3f6 is a hole inside the decoded range
    assign known = idx >= IDX_DIGITAL_OUTPUT && idx <= IDX_FIELD_A_TRACK
        && idx != 10'h3f6;
    function automatic logic [2:0] rateOf(input logic [7:0] c);
        if (c[1:0] == RATE_1M)
            return KBPS_1000;
        return c[1:0] == RATE_500K ? KBPS_500 : KBPS_250;
    endfunction
    property p_wait;
        psel && penable && !pready |=> pready;
    endproperty
    a_wait: assert property (p_wait) else $error("access not two cycles");
    property p_err;
        done && paddr[1:0] == 2'h0 |-> pslverr == !known;
    endproperty
    a_err: assert property (p_err) else $error("decode error flag wrong");
    property p_seek;
        statRd && $past(driveSeekFlag) == $past(driveSeekFlag, 2)
            |-> prdata[3:0] == $past(driveSeekFlag);
    endproperty
    a_seek: assert property (p_seek) else $error("seek bits wrong");
    property p_busy;
        statRd && $past(commandBusy) == $past(commandBusy, 2)
            |-> prdata[4] == $past(commandBusy);
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit wrong");
    property p_strobe;
        done && pwrite && idx == IDX_COMMAND_DATA
            |=> cmdWrStrobe && cmdWrData == $past(wByte);
    endproperty
    a_strobe: assert property (p_strobe) else $error("command byte lost");
    property p_rate;
        rateWr && wByte[1:0] != RATE_ALT
            |-> ##2 dataRate == rateOf($past(wByte, 2));
    endproperty
    a_rate: assert property (p_rate) else $error("data rate wrong");
    property p_low;
        rateWr && wByte[7:6] == 2'h1 |-> ##[1:2] lowPower;
    endproperty
    a_low: assert property (p_low) else $error("low power not entered");
    property p_soft;
        rateWr && wByte[7] |-> ##[1:2] softReset;
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset missing");
endmodule

bind floppy_host_status_rate_regs floppy_regs_props chk_u (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .driveSeekFlag(driveSeekFlag),
    .commandBusy(commandBusy), .cmdWrData(cmdWrData),
    .cmdWrStrobe(cmdWrStrobe), .softReset(softReset),
    .lowPower(lowPower), .dataRate(dataRate)
);

// ==== test/seq_model.sv ====
`timescale 1ns/1ps
module seq_model (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Strobes from the register block
    input wire logic cmdWrStrobe,
    input wire logic [7:0] cmdWrData,
    input wire logic hostRdStrobe,
    // Status and read bytes
    output logic [3:0] driveSeekFlag,
    output logic commandBusy,
    output logic nonDmaExec,
    output logic transferDirection,
    output logic requestForMaster,
    output logic execPhase,
    output logic engRdValid,
    output logic [7:0] engRdData
);
    logic [1:0] left;
    logic pend;
    // Two command bytes, then three polled bytes, one at a time, since
    // the disabled FIFO holds a single byte
    assign nonDmaExec = execPhase;
    assign transferDirection = execPhase;
    assign requestForMaster = !execPhase;
    assign engRdData = 8'ha2 - {6'h0, left};
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            {driveSeekFlag, commandBusy, execPhase} <= '0;
            {engRdValid, left, pend} <= '0;
        end
        else
        begin
            engRdValid <= 1'b0;
            if (hostRdStrobe)
                pend <= 1'b0;
            if (cmdWrStrobe)
            begin
                commandBusy <= 1'b1;
                driveSeekFlag <= commandBusy ? 4'h0 :
                    4'h1 << cmdWrData[1:0];
                execPhase <= commandBusy;
                left <= 2'h3;
            end
            if (execPhase && !pend && !engRdValid)
            begin
                engRdValid <= left != 2'h0;
                pend <= left != 2'h0;
                left <= left - {1'b0, left != 2'h0};
                execPhase <= left != 2'h0;
                commandBusy <= left != 2'h0;
            end
        end
    end
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import floppy_regs_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic diskChange = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, cmdWrStrobe, hostRdStrobe, softReset, e;
    logic lowPower, fifoOverrun, fifoThresholdHit, densityOutput;
    logic [7:0] cmdWrData, precompStartTrack, engRdData, q;
    logic [2:0] dataRate;
    logic [3:0] precompHalfSteps, driveSeekFlag;
    logic [1:0] rateOutputPin;
    logic commandBusy, nonDmaExec, transferDirection, requestForMaster;
    logic execPhase, engRdValid;
    int bad_count = 0;
    int n_checks = 0;
    logic [7:0] pv [7] = '{8'h1e, 8'h06, 8'h1a, 8'h05, 8'h03, 8'h01, 8'h00};
    logic [7:0] pe [7] = '{8'h0, 8'h2, 8'hc, 8'h1, 8'(FIELD_A_DEF_1M),
        8'(FIELD_A_DEF_2M), 8'(FIELD_A_DEF_LOW)};

    floppy_host_status_rate_regs dut_u (.clk(clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .driveSeekFlag(driveSeekFlag),
        .commandBusy(commandBusy), .nonDmaExec(nonDmaExec),
        .transferDirection(transferDirection), .execPhase(execPhase),
        .requestForMaster(requestForMaster), .engRdValid(engRdValid),
        .engRdData(engRdData), .diskChange(diskChange),
        .cmdWrData(cmdWrData), .cmdWrStrobe(cmdWrStrobe),
        .hostRdStrobe(hostRdStrobe), .fifoOverrun(fifoOverrun),
        .fifoThresholdHit(fifoThresholdHit), .softReset(softReset),
        .lowPower(lowPower), .dataRate(dataRate),
        .precompHalfSteps(precompHalfSteps),
        .precompStartTrack(precompStartTrack),
        .densityOutput(densityOutput), .rateOutputPin(rateOutputPin));
    seq_model seq_u (.clk(clk), .sys_rst(sys_rst),
        .cmdWrStrobe(cmdWrStrobe), .cmdWrData(cmdWrData),
        .hostRdStrobe(hostRdStrobe), .driveSeekFlag(driveSeekFlag),
        .commandBusy(commandBusy), .nonDmaExec(nonDmaExec),
        .transferDirection(transferDirection), .execPhase(execPhase),
        .requestForMaster(requestForMaster), .engRdValid(engRdValid),
        .engRdData(engRdData));

    initial forever #20 clk = ~clk;

    task automatic chk(input string s, input logic [7:0] g, x);
        n_checks++;
        if (g !== x)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", s, x, g);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // One APB transfer, then an idle cycle before the next setup
    task automatic apb(input logic w, input logic [9:0] i,
        input logic [7:0] d, output logic [7:0] r, output logic er);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            bad_count++;
        r = prdata[7:0];
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [7:0] expRate(input int o, c);
        if (c == 3)
            return KBPS_1000;
        if (c == 0 || c == 1 && o == 1)
            return KBPS_500;
        if (c == 2)
            return KBPS_250;
        return o == 0 ? KBPS_300 : KBPS_2000;
    endfunction

    initial
    begin
        #400us;
        bad_count++;
        summarize();
    end

    initial
    begin
        int n;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk("rate", {5'h0, dataRate}, KBPS_250);
        chk("field_a", {4'h0, precompHalfSteps}, FIELD_A_DEF_LOW);
        chk("track", precompStartTrack, 8'h00);
        chk("thresh", {7'h0, fifoThresholdHit}, 8'h00);
        apb(1, IDX_DIGITAL_OUTPUT, 8'h04, q, e);
        repeat (2) @(posedge clk);
        chk("softrst", {7'h0, softReset}, 8'h00);
        for (int o = 0; o < 3; o++)
            for (int c = 0; c < 4; c++)
            begin
                apb(1, IDX_ENGINE_CFG, 8'h04 | 8'(o), q, e);
                apb(1, IDX_RATE_STATUS, 8'(c), q, e);
                repeat (3) @(posedge clk);
                chk("rate", {5'h0, dataRate}, expRate(o, c));
                chk("dens", {7'h0, densityOutput}, 8'(c == 0 || c == 3));
                chk("pins", {6'h0, rateOutputPin}, o ? 8'h0 : 8'(c));
            end
        apb(1, IDX_ENGINE_CFG, 8'h02, q, e);
        repeat (3) @(posedge clk);
        chk("dens", {7'h0, densityOutput}, 8'h00);
        foreach (pv[i])
        begin
            apb(1, IDX_RATE_STATUS, pv[i], q, e);
            repeat (3) @(posedge clk);
            chk("field_a", {4'h0, precompHalfSteps}, pe[i]);
        end
        apb(1, IDX_ENGINE_CFG, 8'h04, q, e);
        apb(1, IDX_DISK_INPUT, 8'h03, q, e);
        repeat (3) @(posedge clk);
        chk("rate", {5'h0, dataRate}, KBPS_1000);
        apb(1, IDX_RATE_STATUS, 8'h02, q, e);
        repeat (3) @(posedge clk);
        chk("rate", {5'h0, dataRate}, KBPS_250);
        apb(1, IDX_RATE_STATUS, 8'h83, q, e);
        repeat (4) @(posedge clk);
        chk("softrst", {7'h0, softReset}, 8'h00);
        chk("rate", {5'h0, dataRate}, KBPS_1000);
        apb(1, IDX_RATE_STATUS, 8'h42, q, e);
        chk("lowpwr", {7'h0, lowPower}, 8'h01);
        apb(0, IDX_RATE_STATUS, 8'h00, q, e);
        chk("lowpwr", {7'h0, lowPower}, 8'h00);
        apb(1, IDX_RATE_STATUS, 8'h42, q, e);
        apb(1, IDX_DIGITAL_OUTPUT, 8'h00, q, e);
        @(posedge clk);
        chk("softrst", {7'h0, softReset}, 8'h01);
        apb(1, IDX_DIGITAL_OUTPUT, 8'h04, q, e);
        chk("lowpwr", {7'h0, lowPower}, 8'h00);
        apb(1, IDX_CONFIG_SIX, 8'h1b, q, e);
        apb(1, IDX_CONFIG_SEVEN, 8'h02, q, e);
        apb(1, IDX_FIELD_A_TRACK, 8'h05, q, e);
        chk("track", precompStartTrack, 8'h05);
        apb(1, IDX_TAPE_DRIVE_TYPE, 8'hff, q, e);
        for (int d = 0; d < 4; d++)
        begin
            apb(1, IDX_DIGITAL_OUTPUT, 8'h04 | 8'(d), q, e);
            apb(0, IDX_TAPE_DRIVE_TYPE, 8'h00, q, e);
            chk("tape", q, {2'h0, 2'(3 - d), 4'hb});
        end
        for (int k = 0; k < 2; k++)
        begin
            diskChange <= k[0];
            repeat (5) @(posedge clk);
            apb(0, IDX_DISK_INPUT, 8'h00, q, e);
            chk("dir", q, {!k[0], 7'h0});
        end
        apb(0, 10'h3f6, 8'h00, q, e);
        chk("slverr", {7'h0, e}, 8'h01);
        chk("hole", q, 8'h00);
        apb(1, IDX_COMMAND_DATA, 8'h01, q, e);
        apb(0, IDX_RATE_STATUS, 8'h00, q, e);
        chk("status", q, 8'h92);
        apb(1, IDX_COMMAND_DATA, 8'h00, q, e);
        for (int b = 0; b < 3; b++)
        begin
            n = 0;
            do
            begin
                apb(0, IDX_RATE_STATUS, 8'h00, q, e);
                n++;
            end
            while (q[7] !== 1'b1 && n < 20);
            chk("status", q, 8'hf0);
            apb(0, IDX_COMMAND_DATA, 8'h00, q, e);
            chk("data", q, 8'ha0 + 8'(b));
        end
        repeat (4) @(posedge clk);
        apb(0, IDX_RATE_STATUS, 8'h00, q, e);
        chk("status", q, 8'h80);
        summarize();
    end
endmodule
